/* cfb_can_model.sv */
// can controller model: frame source and transmit sink
`timescale 1ns/1ps
module cfb_can_model
    import cfb_pkg::*;
(
    // clock
    input  wire logic       i_clk,
    // transmit side
    input  wire logic       i_tx_valid,
    input  wire cfb_frame_t i_tx_frame,
    output logic            o_tx_busy,
    // receive side
    output logic            o_rx_valid,
    output cfb_frame_t      o_rx_frame
);
    logic       hold = 1'b0;
    int         n_tx = 0;
    cfb_frame_t last_tx = '0;
    assign o_tx_busy = hold;
    always @(posedge i_clk) begin
        if (i_tx_valid) begin
            n_tx <= n_tx + 1;
            last_tx <= i_tx_frame;
        end
    end
    task automatic send(input cfb_frame_t f);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_frame <= f;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_frame <= ~f;
    endtask
    initial begin
        o_rx_valid = 1'b0;
        o_rx_frame = '0;
    end
endmodule

/* cfb_manager.sv */
// can frame buffer manager with axi4-lite register slave
// What this block does
// - pattern filter gates frames into receive fifo
// - receive fifo holds at most three frames
// - interrupt high while receive fifo not empty
// - exact id check, unmatched frames dropped
// - accepted frame goes to its set's working buffer
// - set holds config, id, working, read buffer
// - many bins may share one buffer set
// - bin records type, set and flag
// - new data sets all enabled sharing bins' flags
// - stale read gives previous or over-range value
// - read clears only requesting bin's flag
// - host data shifted into 64-bit read buffer
// - built frame transmitted or held as response
// - transmit choice sets pending flag
// - scanner cycles over transmit-configured buffers
// - wait while busy, send, then clear
// - response frame moved to working buffer
// - remote request sets pending, normal transmit
// - clear-errors zeroes counters, releases bus-off unless the controller still reports it
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cfb_manager
    import cfb_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // axi4-lite write
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    // axi4-lite read
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // can controller receive side
    input  wire logic        i_rx_valid,
    input  wire cfb_frame_t  i_rx_frame,
    input  wire logic        i_tx_err,
    input  wire logic        i_rx_err,
    input  wire logic        i_wdog_err,
    input  wire logic        i_bus_off,
    // can controller transmit side
    input  wire logic        i_tx_busy,
    output logic             o_tx_valid,
    output cfb_frame_t       o_tx_frame,
    // status
    output logic             o_irq,
    output logic             o_bus_off
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] cfb_mask(input logic [4:0] ln);
        return 32'hFFFF_FFFF >> (5'd31 - ln);
    endfunction

    function automatic logic [31:0] cfb_ext(input logic [63:0] d, input logic [5:0] sb,
                                           input logic [4:0] ln, input logic sg);
        logic [63:0] sh;
        logic [31:0] m;
        logic [31:0] v;
        sh = d >> sb;
        m  = cfb_mask(ln);
        v  = sh[31:0] & m;
        if (sg && v[ln]) begin
            v = v | ~m;
        end
        return v;
    endfunction

    function automatic logic [63:0] cfb_ins(input logic [63:0] d, input logic [5:0] sb,
                                           input logic [4:0] ln, input logic [31:0] val);
        logic [63:0] m;
        m = {32'h0000_0000, cfb_mask(ln)} << sb;
        return (d & ~m) | (({32'h0000_0000, val} << sb) & m);
    endfunction

    function automatic logic [7:0] cfb_inc(input logic [7:0] c, input logic ev);
        return (ev && c != CNT_MAX) ? c + 8'h01 : c;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    cfb_state_t       st;
    cfb_state_t       n;
    logic             rd_take;
    logic             rd_bin;
    logic             clr_hit;
    logic             rx_pass;
    logic [NSET-1:0]  hit;
    cfb_frame_t       head;
    logic [SET_W-1:0] bs;
    logic [SET_W-1:0] ss;
    logic [1:0]       cnt;

    always_comb begin
        n       = st;
        hit     = '0;
        head    = st.fifo[0];
        rd_take = i_arvalid && st.arready;
        rd_bin  = 1'b0;
        clr_hit = 1'b0;
        bs      = st.bin_set[st.bin_sel];
        ss      = st.sel[SET_W-1:0];
        cnt     = st.f_cnt;
        rx_pass = ((i_rx_frame.id ^ st.fcode) & st.fmask) == '0;

        // ----------------------------------------
        // axi read channel
        // ----------------------------------------
        if (st.rvalid && i_rready) begin
            n.rvalid  = 1'b0;
        end
        n.arready = !n.rvalid && !rd_take;
        if (rd_take) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            if (i_araddr == ADDR_CTRL) begin
                n.rdata[CTRL_MR] = st.mr;
            end else if (i_araddr == ADDR_FCODE) begin
                n.rdata[ID_W-1:0] = st.fcode;
            end else if (i_araddr == ADDR_FMASK) begin
                n.rdata[ID_W-1:0] = st.fmask;
            end else if (i_araddr == ADDR_STATUS) begin
                n.rdata[3:0] = {st.busoff, st.irq, st.f_cnt};
            end else if (i_araddr == ADDR_ERRS) begin
                n.rdata = {st.cnt_wd, st.cnt_rx, st.cnt_tx, st.cnt_ovr};
            end else if (i_araddr == ADDR_SEL) begin
                n.rdata[BIN_W-1:0] = st.sel;
            end else if (i_araddr == ADDR_SETCFG) begin
                n.rdata = {1'b0, st.set_tx[ss], st.set_en[ss], st.set_id[ss]};
            end else if (i_araddr == ADDR_BINCFG) begin
                n.rdata[SET_W-1:0]       = st.bin_set[st.sel];
                n.rdata[BINCFG_SGN]      = st.bin_sgn[st.sel];
                n.rdata[BINCFG_ST+:6]    = st.bin_start[st.sel];
                n.rdata[BINCFG_LN+:5]    = st.bin_len[st.sel];
                n.rdata[BINCFG_EN]       = st.bin_en[st.sel];
            end else if (i_araddr == ADDR_BINDATA) begin
                rd_bin = 1'b1;
                if (!st.newf[st.bin_sel] && st.mr) begin
                    n.rdata = OVER_RANGE;
                end else begin
                    n.rdata = cfb_ext(st.wbuf[bs], st.bin_start[st.bin_sel],
                                      st.bin_len[st.bin_sel], st.bin_sgn[st.bin_sel]);
                end
                n.newf[st.bin_sel] = 1'b0;
            end else if (i_araddr == ADDR_NEWF) begin
                n.rdata[NBIN-1:0] = st.newf;
            end else if (i_araddr == ADDR_BINSEL) begin
                n.rdata[BIN_W-1:0] = st.bin_sel;
            end else begin
                n.rresp = RESP_SLV;
            end
        end

        // ----------------------------------------
        // transmit scanner
        // ----------------------------------------
        n.tx_valid = 1'b0;
        case (st.txst)
            CFB_SCAN: begin
                // visit each transmit buffer in turn
                if (st.pend[st.scan] && st.set_tx[st.scan]) begin
                    if (!i_tx_busy) begin
                        n.tx_valid      = 1'b1;
                        n.tx_frame.rtr  = 1'b0;
                        n.tx_frame.id   = st.set_id[st.scan];
                        n.tx_frame.data = st.set_rr[st.scan] ? st.wbuf[st.scan]
                                                             : st.rbuf[st.scan];
                        n.txst          = CFB_SEND;
                    end
                end else begin
                    n.scan = st.scan + 1'b1;
                end
            end
            CFB_SEND: begin
                n.txst = CFB_CLEAR;
            end
            default: begin
                n.pend[st.scan] = 1'b0;
                n.scan          = st.scan + 1'b1;
                n.txst          = CFB_SCAN;
            end
        endcase

        // ----------------------------------------
        // receive fifo and drain
        // ----------------------------------------
        if (st.f_cnt != 2'h0) begin
            for (int s = 0; s < NSET; s++) begin
                if (st.set_en[s] && head.id == st.set_id[s]) begin
                    if (head.rtr) begin
                        if (st.set_rr[s]) begin
                            n.pend[s] = 1'b1;
                        end
                    end else if (!st.set_tx[s]) begin
                        n.wbuf[s] = head.data;
                        hit[s]    = 1'b1;
                    end
                end
            end
            for (int b = 0; b < NBIN; b++) begin
                // every enabled bin on the set flagged together
                // bins share a set through bin_set
                if (st.bin_en[b] && hit[st.bin_set[b]]) begin
                    n.newf[b] = 1'b1;
                end
            end
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                n.fifo[i] = st.fifo[i+1];
            end
            cnt = st.f_cnt - 2'h1;
        end
        if (i_rx_valid && rx_pass) begin
            if (st.f_cnt == FIFO_FULL) begin
                n.cnt_ovr = cfb_inc(st.cnt_ovr, 1'b1);
            end else begin
                n.fifo[cnt] = i_rx_frame;
                cnt         = cnt + 2'h1;
            end
        end
        n.f_cnt = cnt;
        n.irq = cnt != 2'h0;

        // ----------------------------------------
        // error counters
        // ----------------------------------------
        n.cnt_tx = cfb_inc(st.cnt_tx, i_tx_err);
        n.cnt_rx = cfb_inc(st.cnt_rx, i_rx_err);
        n.cnt_wd = cfb_inc(st.cnt_wd, i_wdog_err);
        if (i_bus_off) begin
            n.busoff = 1'b1;
        end

        // ----------------------------------------
        // axi write channel
        // ----------------------------------------
        if (st.bvalid && i_bready) begin
            n.bvalid = 1'b0;
        end
        if (i_awvalid && st.awready) begin
            n.awaddr  = i_awaddr;
            n.aw_have = 1'b1;
        end
        if (i_wvalid && st.wready) begin
            n.wdata  = i_wdata;
            n.wstrb  = i_wstrb;
            n.w_have = 1'b1;
        end
        if (st.aw_have && st.w_have) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            if (st.wstrb != 4'hF) begin
                n.bresp = RESP_OKAY;
            end else if (st.awaddr == ADDR_CTRL) begin
                n.mr = st.wdata[CTRL_MR];
                if (st.wdata[CTRL_CLR]) begin
                    clr_hit   = 1'b1;
                    n.cnt_ovr = 8'h00;
                    n.cnt_tx  = 8'h00;
                    n.cnt_rx  = 8'h00;
                    n.cnt_wd  = 8'h00;
                    // a bus-off still reported by the controller wins
                    n.busoff  = i_bus_off;
                end
            end else if (st.awaddr == ADDR_FCODE) begin
                n.fcode = st.wdata[ID_W-1:0];
            end else if (st.awaddr == ADDR_FMASK) begin
                n.fmask = st.wdata[ID_W-1:0];
            end else if (st.awaddr == ADDR_SEL) begin
                n.sel = st.wdata[BIN_W-1:0];
            end else if (st.awaddr == ADDR_SETCFG) begin
                // id and configuration loaded at setup
                n.set_id[ss] = st.wdata[ID_W-1:0];
                n.set_en[ss] = st.wdata[SETCFG_EN];
                n.set_tx[ss] = st.wdata[SETCFG_TX];
                n.set_rr[ss] = 1'b0;
            end else if (st.awaddr == ADDR_BINCFG) begin
                // bin type, set and own flag
                n.bin_set[st.sel]   = st.wdata[SET_W-1:0];
                n.bin_sgn[st.sel]   = st.wdata[BINCFG_SGN];
                n.bin_start[st.sel] = st.wdata[BINCFG_ST+:6];
                n.bin_len[st.sel]   = st.wdata[BINCFG_LN+:5];
                n.bin_en[st.sel]    = st.wdata[BINCFG_EN];
                n.newf[st.sel]      = 1'b0;
            end else if (st.awaddr == ADDR_BINSEL) begin
                n.bin_sel = st.wdata[BIN_W-1:0];
            end else if (st.awaddr == ADDR_BINDATA) begin
                n.rbuf[bs] = cfb_ins(st.rbuf[bs], st.bin_start[st.bin_sel],
                                     st.bin_len[st.bin_sel], st.wdata);
            end else if (st.awaddr == ADDR_FRMCMD) begin
                if (st.wdata[FRMCMD_RR]) begin
                    n.wbuf[bs]   = st.rbuf[bs];
                    n.set_rr[bs] = 1'b1;
                end else if (st.wdata[FRMCMD_TX]) begin
                    n.set_rr[bs] = 1'b0;
                    n.pend[bs]   = 1'b1;
                end
            end else if (st.awaddr != ADDR_STATUS && st.awaddr != ADDR_ERRS &&
                         st.awaddr != ADDR_NEWF) begin
                n.bresp = RESP_SLV;
            end
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st       <= '0;
            st.fmask <= '0;
            st.txst  <= CFB_SCAN;
        end else begin
            st <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_awready  = st.awready;
    assign o_wready   = st.wready;
    assign o_bresp    = st.bresp;
    assign o_bvalid   = st.bvalid;
    assign o_arready  = st.arready;
    assign o_rdata    = st.rdata;
    assign o_rresp    = st.rresp;
    assign o_rvalid   = st.rvalid;
    assign o_tx_valid = st.tx_valid;
    assign o_tx_frame = st.tx_frame;
    assign o_irq      = st.irq;
    assign o_bus_off  = st.busoff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_fifo_depth_max: assert property (st.f_cnt == FIFO_FULL
        && !(i_rx_valid && rx_pass) |=> st.f_cnt == 2'h2)
        else $error("receive fifo count wrong when full");
    a_irq_tracks_fifo: assert property ((i_rx_valid && rx_pass) |=>
        o_irq && st.f_cnt != 2'h0)
        else $error("irq does not follow fifo");
    a_filter_reject: assert property ((i_rx_valid && !rx_pass) |=>
        st.f_cnt <= $past(st.f_cnt))
        else $error("filtered frame entered fifo");
    a_overrun_count: assert property ((i_rx_valid && rx_pass && st.f_cnt == FIFO_FULL
        && !clr_hit) |=> st.cnt_ovr != 8'h00)
        else $error("overrun not counted");
    a_clear_errors: assert property (clr_hit |=>
        st.cnt_ovr == 8'h00 && st.cnt_tx == 8'h00 && st.cnt_rx == 8'h00 &&
        st.cnt_wd == 8'h00 && st.busoff == $past(i_bus_off))
        else $error("clear errors incomplete");
    a_tx_busy_wait: assert property ((st.txst == CFB_SCAN && i_tx_busy) |=>
        !o_tx_valid)
        else $error("frame sent while busy");
    a_tx_clear_order: assert property (o_tx_valid |-> st.pend[st.scan]
        ##1 st.txst == CFB_CLEAR ##1 st.txst == CFB_SCAN)
        else $error("pending cleared out of order");
    a_tx_one_pulse: assert property (o_tx_valid |=> !o_tx_valid [*2])
        else $error("transmit strobe too long");
    a_over_range: assert property ((rd_bin && !st.newf[st.bin_sel] && st.mr) |=>
        o_rvalid && o_rdata == OVER_RANGE)
        else $error("stale read not over-range");
endmodule

/* cfb_pkg.sv */
// constants, carriers and state layout of the can frame buffer manager
package cfb_pkg;
    // sizes
    localparam int NSET       = 4;
    localparam int NBIN       = 8;
    localparam int FIFO_DEPTH = 3;
    localparam int SET_W      = 2;
    localparam int BIN_W      = 3;
    localparam int ID_W       = 29;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FCODE   = 8'h04;
    localparam logic [7:0] ADDR_FMASK   = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_ERRS    = 8'h10;
    localparam logic [7:0] ADDR_SEL     = 8'h14;
    localparam logic [7:0] ADDR_SETCFG  = 8'h18;
    localparam logic [7:0] ADDR_BINCFG  = 8'h1C;
    localparam logic [7:0] ADDR_BINDATA = 8'h20;
    localparam logic [7:0] ADDR_FRMCMD  = 8'h24;
    localparam logic [7:0] ADDR_NEWF    = 8'h28;
    localparam logic [7:0] ADDR_BINSEL  = 8'h2C;
    // field positions
    localparam int CTRL_MR     = 0;
    localparam int CTRL_CLR    = 1;
    localparam int SETCFG_EN   = 29;
    localparam int SETCFG_TX   = 30;
    localparam int BINCFG_SGN  = 2;
    localparam int BINCFG_ST   = 4;
    localparam int BINCFG_LN   = 10;
    localparam int BINCFG_EN   = 15;
    localparam int FRMCMD_TX   = 0;
    localparam int FRMCMD_RR   = 1;
    // values
    localparam logic [31:0] OVER_RANGE = 32'hFFFE_7961;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;
    localparam logic [1:0]  FIFO_FULL  = 2'h3;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;

    typedef enum logic [1:0] {CFB_SCAN, CFB_SEND, CFB_CLEAR} cfb_txst_t;

    typedef struct packed {
        logic            rtr;
        logic [ID_W-1:0] id;
        logic [63:0]     data;
    } cfb_frame_t;

    typedef struct packed {
        logic [7:0]                        awaddr;
        logic                              aw_have;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              w_have;
        logic                              awready;
        logic                              wready;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              arready;
        logic                              rvalid;
        logic [1:0]                        rresp;
        logic [31:0]                       rdata;
        logic                              mr;
        logic [ID_W-1:0]                   fcode;
        logic [ID_W-1:0]                   fmask;
        logic [BIN_W-1:0]                  sel;
        logic [BIN_W-1:0]                  bin_sel;
        logic [NSET-1:0][ID_W-1:0]         set_id;
        logic [NSET-1:0]                   set_en;
        logic [NSET-1:0]                   set_tx;
        logic [NSET-1:0]                   set_rr;
        logic [NSET-1:0]                   pend;
        logic [NSET-1:0][63:0]             wbuf;
        logic [NSET-1:0][63:0]             rbuf;
        logic [NBIN-1:0][SET_W-1:0]        bin_set;
        logic [NBIN-1:0]                   bin_en;
        logic [NBIN-1:0]                   bin_sgn;
        logic [NBIN-1:0][5:0]              bin_start;
        logic [NBIN-1:0][4:0]              bin_len;
        logic [NBIN-1:0]                   newf;
        cfb_frame_t [FIFO_DEPTH-1:0]       fifo;
        logic [1:0]                        f_cnt;
        logic                              irq;
        logic [7:0]                        cnt_ovr;
        logic [7:0]                        cnt_tx;
        logic [7:0]                        cnt_rx;
        logic [7:0]                        cnt_wd;
        logic                              busoff;
        cfb_txst_t                         txst;
        logic [SET_W-1:0]                  scan;
        logic                              tx_valid;
        cfb_frame_t                        tx_frame;
    } cfb_state_t;
endpackage

/* tb_can_frame_buffer_manager.sv */
// self-checking bench for the can frame buffer manager
`timescale 1ns/1ps
module tb_can_frame_buffer_manager
    import cfb_pkg::*;
;
    logic        clk, rstn, awv, wv, bready, arv, rready, terr, rerr, werr, boin;
    logic        awrdy, wrdy, bv, arrdy, rv, txv, irq, boff, rxv, busy;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdata, got;
    logic [1:0]  bresp, rresp, resp;
    cfb_frame_t  txf, rxf;
    int          mismatches = 0;
    int          n_checks = 0;

    cfb_manager dut_u (.i_clk(clk), .i_resetn(rstn), .i_awaddr(awa), .i_awvalid(awv),
        .o_awready(awrdy), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy),
        .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready), .i_araddr(ara), .i_arvalid(arv),
        .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
        .i_rready(rready), .i_rx_valid(rxv), .i_rx_frame(rxf), .i_tx_err(terr),
        .i_rx_err(rerr), .i_wdog_err(werr), .i_bus_off(boin), .i_tx_busy(busy),
        .o_tx_valid(txv), .o_tx_frame(txf), .o_irq(irq), .o_bus_off(boff));
    cfb_can_model can_u (.i_clk(clk), .i_tx_valid(txv), .i_tx_frame(txf),
        .o_tx_busy(busy), .o_rx_valid(rxv), .o_rx_frame(rxf));

    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arrdy) arv <= 1'b0;
            if (rv) break;
        end
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [95:0] e);
        rd(a);
        chk(got, e);
    endtask
    task automatic wt(input int n, input int c);
        repeat (c) if (can_u.n_tx != n) @(posedge clk);
    endtask

    task automatic t_rx;
        wr(ADDR_FMASK, 32'h0000_0100);
        wr(ADDR_SEL, 32'h0000_0000);
        wr(ADDR_SETCFG, 32'h2000_0010);
        wr(ADDR_BINCFG, 32'h0000_9C80);
        wr(ADDR_SEL, 32'h0000_0001);
        wr(ADDR_BINCFG, 32'h0000_9C00);
        can_u.send({1'b0, 29'h10, 64'h1122_3344_5566_7788});
        #1 chk(irq, 1'b1);
        rdr(ADDR_NEWF, 32'h0000_0003);
        wr(ADDR_BINSEL, 32'h0000_0000);
        rdr(ADDR_BINDATA, 32'h0000_0077);
        rdr(ADDR_NEWF, 32'h0000_0002);
        rdr(ADDR_BINDATA, 32'h0000_0077);
        wr(ADDR_CTRL, 32'h0000_0001);
        rdr(ADDR_BINDATA, OVER_RANGE);
        can_u.send({1'b0, 29'h20, 64'h0000_0000_0000_00FF});
        rdr(ADDR_NEWF, 32'h0000_0002);
        can_u.send({1'b0, 29'h110, 64'h0000_0000_0000_0000});
        #1 chk(irq, 1'b0);
    endtask
    task automatic t_tx;
        can_u.hold <= 1'b1;
        wr(ADDR_SETCFG, 32'h6000_0055);
        wr(ADDR_SEL, 32'h0000_0002);
        wr(ADDR_BINCFG, 32'h0000_BC41);
        wr(ADDR_BINSEL, 32'h0000_0002);
        wr(ADDR_BINDATA, 32'h0000_ABCD);
        wr(ADDR_FRMCMD, 32'h0000_0001);
        wt(1, 20);
        chk(can_u.n_tx, 0);
        can_u.hold <= 1'b0;
        wt(1, 50);
        chk(can_u.last_tx, {1'b0, 29'h55, 64'h0000_0000_000A_BCD0});
        wt(2, 20);
        chk(can_u.n_tx, 1);
    endtask
    task automatic t_rr;
        wr(ADDR_SETCFG, 32'h6000_0066);
        wr(ADDR_SEL, 32'h0000_0003);
        wr(ADDR_BINCFG, 32'h0000_9C02);
        wr(ADDR_BINSEL, 32'h0000_0003);
        wr(ADDR_BINDATA, 32'h0000_005A);
        wr(ADDR_FRMCMD, 32'h0000_0002);
        wt(2, 20);
        chk(can_u.n_tx, 1);
        can_u.send({1'b1, 29'h66, 64'h0000_0000_0000_0000});
        wt(2, 50);
        chk(can_u.last_tx, {1'b0, 29'h66, 64'h0000_0000_0000_005A});
    endtask
    task automatic t_err;
        @(posedge clk);
        {terr, rerr, werr, boin} <= 4'hF;
        @(posedge clk);
        {terr, rerr, werr, boin} <= 4'h0;
        rdr(ADDR_ERRS, 32'h0101_0100);
        chk(boff, 1'b1);
        wr(ADDR_CTRL, 32'h0000_0002);
        chk(resp, RESP_OKAY);
        rdr(ADDR_ERRS, 32'h0000_0000);
        chk(boff, 1'b0);
        rd(8'h3C);
        chk(resp, RESP_SLV);
        wr(8'h3C, 32'h0000_0000);
        chk(resp, RESP_SLV);
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end
    initial begin
        {rstn, awv, wv, bready, arv, rready, terr, rerr, werr, boin} = '0;
        {awa, ara, wd} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rdr(ADDR_STATUS, 32'h0000_0000);
        t_rx;
        t_tx;
        t_rr;
        t_err;
        final_report;
    end
endmodule
